// ==== bench/cfg_mem_model.sv ====
// Purpose: Behavioural configuration memory on the loader's read port
// Assumes: One request at a time, answered after 0..3 idle cycles
// Notes:   Data lines toggle when no word is being returned, except in the cycle a request is taken
`timescale 1ns/1ps
module cfg_mem_model
  import cfg_loader_pkg::*;
(
  input  wire logic     pclk,    // Core clock
  input  wire logic     presetn, // Async reset, active low
  input  wire mem_req_t mem_req, // Read request
  output mem_rsp_t      mem_rsp  // Read answer
);
  logic [15:0] words [0:127];
  logic        pend;
  logic [7:0]  addr;
  int          wait_cnt;
  int          nreq;

  ////////////////////////////////////////////////////////////////
  // Answer one request; idle data inverts so stale words never match
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rsp <= '0;
      pend    <= 1'b0;
      nreq    <= 0;
    end else begin
      mem_rsp.valid <= 1'b0;
      if (mem_req.req) begin
        pend     <= 1'b1;
        addr     <= mem_req.addr;
        wait_cnt <= $urandom_range(0, 3);
        nreq     <= nreq + 1;
      end else if (pend && wait_cnt == 0) begin
        pend          <= 1'b0;
        mem_rsp.valid <= 1'b1;
        mem_rsp.data  <= words[addr[7:1]];
      end else begin
        if (pend) wait_cnt <= wait_cnt - 1;
        mem_rsp.data <= ~mem_rsp.data;
      end
    end
  end
endmodule

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench for the configuration word loader
// Assumes: APB master at pclk, memory model on the read port
// Notes:   Expected read values queued by the driver, checked by a monitor
`timescale 1ns/1ps
module testbench;
  import cfg_loader_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, load_done, ld;
  mem_req_t    mem_req;
  mem_rsp_t    mem_rsp;
  int          mismatches = 0, check_count = 0;
  logic [33:0] notes [$];
  logic [33:0] e;
  logic [15:0] w [0:8];
  logic [1:0]  p;
  logic [7:0]  ra [12] = '{8'h00, 8'h08, 8'h3C, 8'hA8, 8'hB0, 8'hB4, 8'hB8, 8'hC4, 8'hE4, 8'hEC, 8'hF8, 8'hFC};

  always #5 pclk = ~pclk;

  cfg_word_loader dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .load_done(load_done));
  cfg_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_rsp(mem_rsp));

  ////////////////////////////////////////////////////////////////
  // Expected {pslverr, prdata} for the selected port
  function automatic logic [32:0] expv(input logic [7:0] a);
    logic lp;
    lp = (p != 2'd3);
    case (a)
      8'h00: return {1'b0, w[2], w[1]};
      8'h08: return {9'h0, 16'h0, w[7][7:0]};
      8'h3C: return {24'h0, (p == 2'd1 || p == 2'd2) & w[3][15], 8'h0};
      8'hA8: return {18'h0, (p == 2'd0) ? w[8][9:8] : 2'b00, 13'h0};
      8'hB0: return {17'h0, w[6][5], w[6][4], w[6][7], 13'h0};
      8'hB4: return {17'h0, w[6][6], 7'h0, w[6][10],
                     lp ? {w[3][9], w[3][8], w[3][14], w[3][13], w[3][12:11], w[3][10]} : 7'h0};
      8'hB8: return {17'h0, w[6][15], w[6][14], w[6][13], w[6][11], 4'h0, (p == 2'd0) ? w[8][7:0] : 8'h0};
      8'hC4: return {1'b0, w[5], w[4]};
      8'hE4: return {17'h0, w[6][3], 14'h0, w[6][0]};
      8'hEC: return {13'h0, (p != 2'd0) & w[6][12], 1'b0, lp ? w[3][6:1] : 6'h0, w[6][2:1], 10'h0};
      8'hF8: return {31'h0, p};
      8'hFC: return {31'h0, 1'b1, ld};
      default: return {1'b1, 32'h0};
    endcase
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    notes.push_back({wr, x});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, expv(a));
  endtask

  task automatic reset_dut();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Monitor: oldest note against each answer; writes check pslverr only
  always @(posedge pclk) begin
    if (pready === 1'b1 && notes.size() != 0) begin
      e = notes.pop_front();
      check(e[33] ? {pslverr, 32'h0} : {pslverr, prdata}, e[32:0]);
    end
  end

  initial begin
    #300000;
    mismatches++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h88D3));
    // Bad signature: defaults kept, read issued while loading stalls
    foreach (w[i]) w[i] = DEF_WORD;
    w[1] = DEF_VENDOR;
    w[2] = DEF_DEVICE;
    for (int i = 0; i < 9; i++) mem.words[i] = 16'(~SIGNATURE_VALUE);
    ld = 1'b0;
    p  = 2'd0;
    reset_dut();
    check({32'h0, load_done}, 33'd0);
    rd(RA_ID);
    check({32'h0, load_done}, 33'd1);
    rd(RA_STATUS);
    check({1'b0, 32'(mem.nreq)}, 33'd1);
    $display("test defaults done");
    // Good signature, random image, every port and field
    ld = 1'b1;
    for (int t = 0; t < 2; t++) begin
      for (int i = 0; i < 9; i++) w[i] = 16'($urandom);
      w[0] = SIGNATURE_VALUE;
      for (int i = 0; i < 9; i++) mem.words[i] = w[i];
      reset_dut();
      check({32'h0, load_done}, 33'd0);
      for (int k = 0; k < 4; k++) begin
        apb(1'b1, RA_PORTSEL, 32'(k), 33'h0);
        p = 2'(k);
        foreach (ra[j]) rd(ra[j]);
      end
      apb(1'b1, RA_REV, 32'hFFFF_FFFF, 33'h0);
      rd(RA_REV);
      rd(8'h10);
      check({32'h0, load_done}, 33'd1);
      check({1'b0, 32'(mem.nreq)}, 33'd9);
      $display("test loaded image %0d done", t);
    end
    print_verdict();
  end
endmodule

// ==== verilog/cfg_loader_pkg.sv ====
// Purpose: Shared constants and types for the configuration word loader
// Assumes: 16-bit configuration memory words, APB register access
// Notes:   Word addresses are byte addresses of 16-bit words in the memory
package cfg_loader_pkg;

  // Memory word addresses
  localparam logic [7:0] WA_SIGNATURE = 8'h00;
  localparam logic [7:0] WA_VENDOR    = 8'h02;
  localparam logic [7:0] WA_DEVICE    = 8'h04;
  localparam logic [7:0] WA_LINK      = 8'h06;
  localparam logic [7:0] WA_SUBVEN    = 8'h08;
  localparam logic [7:0] WA_SUBSYS    = 8'h0A;
  localparam logic [7:0] WA_CAPS      = 8'h0C;
  localparam logic [7:0] WA_REVISION  = 8'h0E;
  localparam logic [7:0] WA_PHY0      = 8'h10;
  localparam logic [7:0] WA_LAST      = 8'h10;

  // Signature value; arbitrary neutral value
  localparam logic [15:0] SIGNATURE_VALUE = 16'hC0DE;

  // APB register byte addresses (configuration offsets, 32-bit aligned)
  localparam logic [7:0] RA_ID        = 8'h00;
  localparam logic [7:0] RA_REV       = 8'h08;
  localparam logic [7:0] RA_INTPIN    = 8'h3C;
  localparam logic [7:0] RA_PMDATA    = 8'hA8;
  localparam logic [7:0] RA_CAPDIS    = 8'hB0;
  localparam logic [7:0] RA_SWMODE    = 8'hB4;
  localparam logic [7:0] RA_PHYCTL    = 8'hB8;
  localparam logic [7:0] RA_SUBSYS    = 8'hC4;
  localparam logic [7:0] RA_DEVCAP    = 8'hE4;
  localparam logic [7:0] RA_LINKCAP   = 8'hEC;
  localparam logic [7:0] RA_PORTSEL   = 8'hF8;
  localparam logic [7:0] RA_STATUS    = 8'hFC;

  // Built-in defaults used when no valid memory image is present
  // Identification defaults are arbitrary values
  localparam logic [15:0] DEF_VENDOR  = 16'h1234;
  localparam logic [15:0] DEF_DEVICE  = 16'h5678;
  localparam logic [15:0] DEF_WORD    = 16'h0000;

  // Memory read request and answer
  typedef struct packed {
    logic       req;
    logic [7:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } mem_rsp_t;

endpackage

// ==== verilog/cfg_word_loader.sv ====
// Purpose: Loads configuration words from external memory into port
//          configuration fields, served to software over APB
// Assumes: Memory read port answers with one valid pulse per request
// Notes:   APB accesses are held off (pready low) until loading ends
`timescale 1ns/1ps
module cfg_word_loader
  import cfg_loader_pkg::*;
(
  input  wire logic        pclk,      // Core clock, 100 MHz
  input  wire logic        presetn,   // Async reset, active low
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB access phase
  input  wire logic        pwrite,    // APB write
  input  wire logic [7:0]  paddr,     // APB byte address
  input  wire logic [31:0] pwdata,    // APB write data
  output logic      [31:0] prdata,    // APB read data
  output logic             pready,    // APB ready
  output logic             pslverr,   // APB error
  output mem_req_t         mem_req,   // Memory read request
  input  wire mem_rsp_t    mem_rsp,   // Memory read answer
  output logic             load_done  // Loading finished
);

  ////////////////////////////////////////////////////////////////////////
  // Load sequencer
  typedef enum {S_SIG_REQ, S_SIG_WAIT, S_REQ, S_WAIT, S_DONE} state_t;
  state_t     state;
  state_t     next_state;
  logic [7:0] addr;
  logic [7:0] next_addr;
  logic       word_in;
  logic       sig_ok;

  assign word_in = (state == S_WAIT) && mem_rsp.valid;

  // Signature seen and equal; only then do the later words load
  wire sig_match = (state == S_SIG_WAIT) && mem_rsp.valid && (mem_rsp.data == SIGNATURE_VALUE);

  // Next state and address
  always_comb begin
    next_state = state;
    next_addr  = addr;
    unique case (state)
      S_SIG_REQ: begin
        next_state = S_SIG_WAIT;
      end
      S_SIG_WAIT: begin
        if (mem_rsp.valid) begin
          next_state = (mem_rsp.data == SIGNATURE_VALUE) ? S_REQ : S_DONE;
          next_addr  = WA_VENDOR;
        end
      end
      S_REQ: begin
        next_state = S_WAIT;
      end
      S_WAIT: begin
        if (mem_rsp.valid) begin
          next_state = (addr == WA_LAST) ? S_DONE : S_REQ;
          next_addr  = addr + 8'h02;
        end
      end
      S_DONE: begin
        next_state = S_DONE;
      end
    endcase
  end

  // State registers; request is a registered pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= S_SIG_REQ;
      addr      <= WA_SIGNATURE;
      mem_req   <= '0;
      load_done <= 1'b0;
      sig_ok    <= 1'b0;
    end else begin
      state        <= next_state;
      addr         <= next_addr;
      // Pulse follows a request state, so the first one leaves right after reset
      mem_req.req  <= (state == S_SIG_REQ) || (state == S_REQ);
      mem_req.addr <= addr;
      load_done    <= (next_state == S_DONE);
      sig_ok       <= sig_ok || sig_match;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Word stores, one per loaded word (02h..10h)
  localparam int NWORDS = 8;
  logic [15:0] w [NWORDS];

  genvar gi;
  generate
    for (gi = 0; gi < NWORDS; gi++) begin : g_word
      localparam logic [15:0] DEF = (gi == 0) ? DEF_VENDOR :
                                    (gi == 1) ? DEF_DEVICE : DEF_WORD;
      cfg_word_store #(.DEFAULT(DEF)) u_store (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (word_in && (addr == 8'((gi + 1) * 2))),
        .din     (mem_rsp.data),
        .q       (w[gi])
      );
    end
  endgenerate

  // Named word views
  wire [15:0] w_vendor = w[0];
  wire [15:0] w_device = w[1];
  wire [15:0] w_link   = w[2];
  wire [15:0] w_subven = w[3];
  wire [15:0] w_subsys = w[4];
  wire [15:0] w_caps   = w[5];
  wire [15:0] w_rev    = w[6];
  wire [15:0] w_phy0   = w[7];

  ////////////////////////////////////////////////////////////////////////
  // Field mapping into configuration register images, per port
  logic [1:0] port;   // Software-selected port for reads
  wire        p0   = (port == 2'd0);
  wire        p012 = (port != 2'd3);
  wire        p12  = (port == 2'd1) || (port == 2'd2);
  wire        p123 = (port != 2'd0);

  wire [31:0] img_id = {w_device, w_vendor};

  wire [31:0] img_rev = {24'h000000, w_rev[7:0]};

  wire [31:0] img_intpin = {23'h000000, p12 & w_link[15], 8'h00};

  wire [31:0] img_pmdata = {17'h00000, p0 ? w_phy0[9:8] : 2'b00, 13'h0000};

  wire [31:0] img_capdis = {16'h0000, w_caps[5], w_caps[4], w_caps[7], 13'h0000};

  wire [6:0]  swm = p012 ? {w_link[9], w_link[8], w_link[14], w_link[13],
                            w_link[12:11], w_link[10]} : 7'h00;
  wire [31:0] img_swmode = {16'h0000, w_caps[6], 7'h00, w_caps[10], swm};

  wire [7:0]  fast_training_sequence_count = p0 ? w_phy0[7:0] : 8'h00;
  wire [31:0] img_phyctl = {16'h0000, w_caps[15], w_caps[14], w_caps[13],
                            w_caps[11], 4'h0, fast_training_sequence_count};

  wire [31:0] img_subsys = {w_subsys, w_subven};

  wire [31:0] img_devcap = {16'h0000, w_caps[3], 14'h0000, w_caps[0]};

  wire [2:0]  l0s = p012 ? w_link[3:1] : 3'b000;
  wire [2:0]  l1  = p012 ? w_link[6:4] : 3'b000;
  wire [31:0] img_linkcap = {12'h000, p123 & w_caps[12], 1'b0, l1, l0s,
                             w_caps[2:1], 10'h000};

  ////////////////////////////////////////////////////////////////////////
  // APB slave
  wire access  = psel && penable;
  wire wr_sel  = access && pwrite && (paddr == RA_PORTSEL);
  wire mapped  = (paddr == RA_ID) || (paddr == RA_REV) || (paddr == RA_INTPIN) ||
                 (paddr == RA_PMDATA) || (paddr == RA_CAPDIS) ||
                 (paddr == RA_SWMODE) || (paddr == RA_PHYCTL) ||
                 (paddr == RA_SUBSYS) || (paddr == RA_DEVCAP) ||
                 (paddr == RA_LINKCAP) || (paddr == RA_PORTSEL) ||
                 (paddr == RA_STATUS);

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      RA_ID:      rd_mux = img_id;
      RA_REV:     rd_mux = img_rev;
      RA_INTPIN:  rd_mux = img_intpin;
      RA_PMDATA:  rd_mux = img_pmdata;
      RA_CAPDIS:  rd_mux = img_capdis;
      RA_SWMODE:  rd_mux = img_swmode;
      RA_PHYCTL:  rd_mux = img_phyctl;
      RA_SUBSYS:  rd_mux = img_subsys;
      RA_DEVCAP:  rd_mux = img_devcap;
      RA_LINKCAP: rd_mux = img_linkcap;
      RA_PORTSEL: rd_mux = {30'h0, port};
      RA_STATUS:  rd_mux = {30'h0, state == S_DONE, sig_ok};
      default:    rd_mux = 32'h00000000;
    endcase
  end

  // Registered answer; one wait state keeps outputs flopped
  // hold until loaded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access && load_done && !pready;
      pslverr <= access && load_done && !pready && !mapped;
      prdata  <= (access && !pwrite && load_done && !pready) ? rd_mux : 32'h00000000;
    end
  end

  // Port select register, written only at completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port <= 2'd0;
    end else if (wr_sel && pready) begin
      port <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Sequencer: signature gate, request pulses and word order
  a_sig_bad_skip: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_SIG_WAIT && mem_rsp.valid && mem_rsp.data != SIGNATURE_VALUE) |=> state == S_DONE)
    else $error("bad signature not skipped");
  a_sig_gate: assert property (@(posedge pclk) disable iff (!presetn)
    sig_match |=> (sig_ok && state == S_REQ))
    else $error("good signature not followed by loading");
  a_sig_req_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (mem_req.req && !sig_ok) |-> mem_req.addr == WA_SIGNATURE)
    else $error("first request not at signature word");
  a_req_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req.req |=> !mem_req.req)
    else $error("memory request longer than one cycle");
  a_addr_order: assert property (@(posedge pclk) disable iff (!presetn)
    (word_in && addr != WA_LAST) |=> (state == S_REQ && addr == $past(addr) + 8'h02))
    else $error("word order broken");
  a_default_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (load_done && !sig_ok) |-> (w_vendor == DEF_VENDOR && w_device == DEF_DEVICE))
    else $error("defaults lost without signature");
  a_done_holds: assert property (@(posedge pclk) disable iff (!presetn)
    load_done |=> load_done)
    else $error("load done dropped");

  // Host side: nothing answered before loading ends
  a_no_ready_early: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> load_done)
    else $error("ready before load done");
  a_stall_no_ready: assert property (@(posedge pclk) disable iff (!presetn)
    !load_done |=> !pready)
    else $error("ready raised while loading");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
  a_read_zero_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0)
    else $error("read data outside ready cycle");
  a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_sel && pready) |=> port == $past(pwdata[1:0]))
    else $error("port select not written");

  // Word capture from the memory answer
  a_vendor_load: assert property (@(posedge pclk) disable iff (!presetn)
    (word_in && addr == WA_VENDOR) |=> w_vendor == $past(mem_rsp.data))
    else $error("vendor word not loaded");
  a_device_load: assert property (@(posedge pclk) disable iff (!presetn)
    (word_in && addr == WA_DEVICE) |=> img_id[31:16] == $past(mem_rsp.data))
    else $error("device word not loaded");
  a_link_load: assert property (@(posedge pclk) disable iff (!presetn)
    (word_in && addr == WA_LINK) |=> w_link == $past(mem_rsp.data))
    else $error("link word not loaded");
  a_subsys_load: assert property (@(posedge pclk) disable iff (!presetn)
    (word_in && addr == WA_SUBSYS) |=> img_subsys[31:16] == $past(mem_rsp.data))
    else $error("subsystem word not loaded");
  a_caps_load: assert property (@(posedge pclk) disable iff (!presetn)
    (word_in && addr == WA_CAPS) |=> w_caps == $past(mem_rsp.data))
    else $error("capability word not loaded");
  a_rev_load: assert property (@(posedge pclk) disable iff (!presetn)
    (word_in && addr == WA_REVISION) |=> w_rev == $past(mem_rsp.data))
    else $error("revision word not loaded");
  a_phy_load: assert property (@(posedge pclk) disable iff (!presetn)
    (word_in && addr == WA_PHY0) |=> w_phy0 == $past(mem_rsp.data))
    else $error("port 0 link word not loaded");

  // Port gating and mapping of the images
  a_surprise_port0: assert property (@(posedge pclk) disable iff (!presetn)
    p0 |-> !img_linkcap[19])
    else $error("surprise down on port 0");
  a_inta_ports: assert property (@(posedge pclk) disable iff (!presetn)
    !p12 |-> !img_intpin[8])
    else $error("INTA bit outside ports 1-2");
  a_fts_port0: assert property (@(posedge pclk) disable iff (!presetn)
    p0 |-> img_phyctl[7:0] == w_phy0[7:0])
    else $error("training count wrong");
  a_rev_map: assert property (@(posedge pclk) disable iff (!presetn)
    img_rev[7:0] == w_rev[7:0])
    else $error("revision map wrong");
  a_ppm_port0: assert property (@(posedge pclk) disable iff (!presetn)
    !p0 |-> img_pmdata[14:13] == 2'b00)
    else $error("clock ppm outside port 0");
  a_swmode_port3: assert property (@(posedge pclk) disable iff (!presetn)
    !p012 |-> img_swmode[6:0] == 7'h00)
    else $error("switch mode bits on port 3");
  a_latency_port3: assert property (@(posedge pclk) disable iff (!presetn)
    !p012 |-> img_linkcap[17:12] == 6'h00)
    else $error("exit latency on port 3");

endmodule

// ==== verilog/cfg_word_store.sv ====
// Purpose: Holds one loaded 16-bit configuration word with a default
// Assumes: Load strobe from the sequencer on the same clock
// Notes:   One instance per loaded word (02h..10h); the signature word has none
`timescale 1ns/1ps
module cfg_word_store
  import cfg_loader_pkg::*;
#(
  parameter logic [15:0] DEFAULT = 16'h0000
) (
  input  wire logic        pclk,    // Core clock
  input  wire logic        presetn, // Async reset, active low
  input  wire logic        load,    // Capture strobe
  input  wire logic [15:0] din,     // Word from memory
  output logic      [15:0] q        // Stored word
);

  // Reset to default; async reset loads a constant only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= DEFAULT;
    end else if (load) begin
      q <= din;
    end
  end

endmodule
